// >>> core/tps_consts.svh
// named constants for the task priority scheduler
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH
`define TPS_NUM_CYC      8
`define TPS_NUM_IO       8
`define TPS_NUM_TASKS    16
`define TPS_PRIO_MOST    3'h2
`define TPS_PRIO_LEAST   3'h7
`define TPS_PRIO_W       3
`define TPS_TICK_NS      1000000
`define TPS_CLK_NS       8
`define TPS_EDGE_RISING  1'h0
`define TPS_EDGE_FALLING 1'h1
`endif

// >>> core/tps_pkg.sv
// types shared by the task priority scheduler files
package tps_pkg;
	typedef enum logic [1:0] {
		TPS_RUN_SCAN,
		TPS_RUN_INIT,
		TPS_RUN_TASK
	} tps_kind_t;

	typedef struct packed {
		tps_kind_t  kind;
		logic [3:0] task_id;
	} tps_status_t;
endpackage

// >>> core/tps_interval_timer.sv
// millisecond interval timer that raises one cyclic task request
`timescale 1ns/1ps
`include "tps_consts.svh"
module tps_interval_timer #(
	parameter int W = 32
) (
	input  wire logic         core_clk_in,   // controller clock
	input  wire logic         sys_rst_in,    // async reset, high
	input  wire logic         tick_in,       // one pulse per millisecond
	input  wire logic         run_in,        // run mode level
	input  wire logic         enable_in,     // task configured
	input  wire logic [W-1:0] interval_in,   // interval in ms, 0 = off
	output logic              expire_out     // request pulse
);
	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;
	logic         expire_next;
	logic         active;
	logic         reach;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// time outside run mode is frozen, not lost and not counted
	assign active      = enable_in && (interval_in != '0);
	assign reach       = (count_reg + 1'b1) >= interval_in;
	assign expire_next = active && run_in && tick_in && reach;
	assign count_next  = !active ? '0 :
	                     !(run_in && tick_in) ? count_reg :
	                     reach ? '0 : count_reg + 1'b1;

	// counter and request register
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_reg  <= '0;
			expire_out <= 1'b0;
		end else begin
			count_reg  <= count_next;
			expire_out <= expire_next;
		end
	end
endmodule

// >>> core/tps_scheduler.sv
// task priority scheduler: requests, arbitration, pre-emption, status
//
// What this block does
// - task priority levels 2..7, 2 most urgent
// - most urgent pending task is granted first
// - equal levels granted in arrival order
// - no task starts during initialization task
// - scan lowest; suspended while any task runs
// - disable instruction blocks starts until enable
// - initialization ignores disable and enable masking
// - starts wait for subroutine call to finish
// - cyclic request each time interval elapses
// - cyclic request dropped if already pending/running
// - interval timers advance only in run mode
// - io request on configured input edge
// - io edge selectable rising or falling
// - io request dropped if already pending/running
// - io requests dropped outside run mode
`timescale 1ns/1ps
`include "tps_consts.svh"
module tps_scheduler #(
	parameter int NC        = `TPS_NUM_CYC,
	parameter int NI        = `TPS_NUM_IO,
	parameter int TW        = 32,
	parameter int MS_CYCLES = `TPS_TICK_NS / `TPS_CLK_NS
) (
	input  wire logic               core_clk_in,         // 125 MHz clock
	input  wire logic               sys_rst_in,          // async reset, high
	input  wire logic               run_mode_in,         // 1 run, 0 stop
	input  wire logic               init_active_in,      // initialization task running
	input  wire logic               task_start_disable_instr_in, // disable pulse
	input  wire logic               task_start_enable_instr_in,  // enable pulse
	input  wire logic               subroutine_call_instr_in,    // call busy level
	input  wire logic               task_done_in,        // current task finished pulse
	input  wire logic [NC-1:0]      cyc_enable_in,       // cyclic task configured
	input  wire logic [NC*TW-1:0]   cyc_interval_in,     // intervals in ms
	input  wire logic [NI-1:0]      io_enable_in,        // io task configured
	input  wire logic [NI-1:0]      io_edge_sel_in,      // 0 rising, 1 falling
	input  wire logic [NI-1:0]      external_interrupt_inputs_in, // async pins
	input  wire logic [(NC+NI)*3-1:0] prio_cfg_in,       // 3 bits per task
	output tps_pkg::tps_status_t    status_out,          // who runs now
	output logic                    scan_suspend_out,    // scan program held
	output logic                    task_start_out,      // start pulse
	output logic [3:0]              task_start_id_out,   // task started
	output logic [NC+NI-1:0]        pending_out,         // waiting tasks
	output logic                    starts_masked_out    // disable in force
);
	localparam int N = NC + NI;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// out-of-range levels fold into 2..7 so arbitration stays total
	function automatic logic [2:0] clamp_prio(input logic [2:0] p);
		if (p < `TPS_PRIO_MOST) begin
			clamp_prio = `TPS_PRIO_MOST;
		end else begin
			clamp_prio = p;
		end
	endfunction

	logic [2:0] prio [N];
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_prio
			assign prio[g] = clamp_prio(prio_cfg_in[g*`TPS_PRIO_W +: `TPS_PRIO_W]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// millisecond tick
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt_reg;
	logic        tick;
	assign tick = (tick_cnt_reg == 32'(MS_CYCLES - 1));

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tick_cnt_reg <= 32'h0;
		end else begin
			tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// request sources
	// ----------------------------------------------------------------
	logic [NC-1:0] cyc_req;
	logic [NI-1:0] io_s1_reg;
	logic [NI-1:0] io_s2_reg;
	logic [NI-1:0] io_s3_reg;
	logic [NI-1:0] io_req;

	generate
		for (g = 0; g < NC; g++) begin : g_cyc
			tps_interval_timer #(.W(TW)) u_timer (
				.core_clk_in (core_clk_in),
				.sys_rst_in  (sys_rst_in),
				.tick_in     (tick),
				.run_in      (run_mode_in),
				.enable_in   (cyc_enable_in[g]),
				.interval_in (cyc_interval_in[g*TW +: TW]),
				.expire_out  (cyc_req[g])
			);
		end
	endgenerate

	// pins pass two flops; the third stage holds the previous level
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			io_s1_reg <= '0;
			io_s2_reg <= '0;
			io_s3_reg <= '0;
		end else begin
			io_s1_reg <= external_interrupt_inputs_in;
			io_s2_reg <= io_s1_reg;
			io_s3_reg <= io_s2_reg;
		end
	end

	// edge select per input; stop mode drops the edge outright
	generate
		for (g = 0; g < NI; g++) begin : g_io
			assign io_req[g] = io_enable_in[g] && run_mode_in &&
				((io_edge_sel_in[g] == `TPS_EDGE_RISING) ?
				 (io_s2_reg[g] && !io_s3_reg[g]) :
				 (!io_s2_reg[g] && io_s3_reg[g]));
		end
	endgenerate

	// ----------------------------------------------------------------
	// pending, running and arrival order
	// ----------------------------------------------------------------
	logic [N-1:0] pend_reg;
	logic [N-1:0] pend_next;
	logic [N-1:0] act_reg;
	logic [N-1:0] act_next;
	logic [N-1:0] raw_req;
	logic [N-1:0] arrive;
	logic [N-1:0] older_reg [N]; // older_reg[i][j]: i arrived before j
	logic         mask_reg;

	assign raw_req = {io_req, cyc_req};
	// a request for a task already waiting or running is discarded
	assign arrive  = raw_req & ~pend_reg & ~act_reg;

	// winner among pending: more urgent, or same level and older
	logic [N-1:0] wins;
	generate
		for (g = 0; g < N; g++) begin : g_win
			logic [N-1:0] beats;
			for (genvar h = 0; h < N; h++) begin : g_cmp
				assign beats[h] = (h == g) || !pend_reg[h] ||
					(prio[g] < prio[h]) ||
					((prio[g] == prio[h]) && older_reg[g][h]);
			end
			assign wins[g] = pend_reg[g] && (&beats);
		end
	endgenerate

	// current task is the most urgent running one; nesting is strict
	logic [N-1:0] cur_onehot;
	generate
		for (g = 0; g < N; g++) begin : g_cur
			logic [N-1:0] above;
			for (genvar h = 0; h < N; h++) begin : g_cmp
				assign above[h] = (h == g) || !act_reg[h] || (prio[g] < prio[h]);
			end
			assign cur_onehot[g] = act_reg[g] && (&above);
		end
	endgenerate

	function automatic logic [3:0] enc(input logic [N-1:0] v);
		enc = 4'h0;
		for (int k = 0; k < N; k++) begin
			if (v[k]) begin
				enc = 4'(k);
			end
		end
	endfunction

	logic [3:0] best_id;
	logic [3:0] cur_id;
	logic       any_act;
	logic       preempt_ok;
	logic       grant;
	assign best_id    = enc(wins);
	assign cur_id     = enc(cur_onehot);
	assign any_act    = |act_reg;
	assign preempt_ok = !any_act || (prio[best_id] < prio[cur_id]);
	assign grant      = (|wins) && preempt_ok && !init_active_in &&
	                    !mask_reg &&
	                    !subroutine_call_instr_in &&
	                    !task_done_in;

	assign pend_next = (pend_reg | arrive) & ~(grant ? (N'(1) << best_id) : '0);
	assign act_next  = (act_reg & ~(task_done_in ? cur_onehot : '0)) |
	                   (grant ? (N'(1) << best_id) : '0);

	// pending and running sets plus order matrix
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pend_reg <= '0;
			act_reg  <= '0;
			for (int i = 0; i < N; i++) begin
				older_reg[i] <= '0;
			end
		end else begin
			pend_reg <= pend_next;
			act_reg  <= act_next;
			// simultaneous arrivals order by lower index first
			for (int i = 0; i < N; i++) begin
				for (int j = 0; j < N; j++) begin
					if (arrive[j] && !(arrive[i] && i > j)) begin
						older_reg[i][j] <= (i != j);
					end else if (arrive[i]) begin
						older_reg[i][j] <= 1'b0;
					end
				end
			end
		end
	end

	// disable/enable mask; enable wins if both pulse together
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mask_reg <= 1'b0;
		end else if (task_start_enable_instr_in) begin
			mask_reg <= 1'b0;
		end else if (task_start_disable_instr_in) begin
			mask_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// running task id after this edge: the most urgent one left active;
	// a grant is strictly more urgent than every running task, so it wins
	logic [3:0]   cur_id_after;
	logic [N-1:0] left_act;
	generate
		for (g = 0; g < N; g++) begin : g_left
			logic [N-1:0] above;
			for (genvar h = 0; h < N; h++) begin : g_cmp
				assign above[h] = (h == g) || !act_next[h] || (prio[g] < prio[h]);
			end
			assign left_act[g] = act_next[g] && (&above);
		end
	endgenerate
	assign cur_id_after = enc(left_act);

	// init is reported whatever the mask says; mask only gates tasks
	tps_pkg::tps_status_t status_next;
	assign status_next.kind    = init_active_in ? tps_pkg::TPS_RUN_INIT :
	                             (|act_next) ? tps_pkg::TPS_RUN_TASK :
	                             tps_pkg::TPS_RUN_SCAN;
	assign status_next.task_id = cur_id_after;

	// registered outputs
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			status_out        <= '{kind: tps_pkg::TPS_RUN_SCAN, task_id: 4'h0};
			scan_suspend_out  <= 1'b0;
			task_start_out    <= 1'b0;
			task_start_id_out <= 4'h0;
		end else begin
			status_out        <= status_next;
			scan_suspend_out  <= init_active_in || (|act_next);
			task_start_out    <= grant;
			task_start_id_out <= grant ? best_id : task_start_id_out;
		end
	end

	assign pending_out       = pend_reg;
	assign starts_masked_out = mask_reg;
endmodule

// >>> verif/tps_scheduler_monitor.sv
// checker watching the task priority scheduler ports
`timescale 1ns/1ps
module tps_scheduler_monitor #(
	parameter int NC = 8,
	parameter int NI = 8
) (
	input wire logic                 core_clk_in,                 // clock
	input wire logic                 sys_rst_in,                  // reset
	input wire logic                 run_mode_in,                 // run level
	input wire logic                 init_active_in,              // init running
	input wire logic                 task_start_disable_instr_in, // disable pulse
	input wire logic                 task_start_enable_instr_in,  // enable pulse
	input wire logic                 subroutine_call_instr_in,    // call busy
	input wire tps_pkg::tps_status_t status_out,                  // who runs
	input wire logic                 scan_suspend_out,            // scan held
	input wire logic                 task_start_out,              // start pulse
	input wire logic [3:0]           task_start_id_out,           // started id
	input wire logic [NC+NI-1:0]     pending_out,                 // pending set
	input wire logic                 starts_masked_out            // mask in force
);
	// --------
	// start blocking, masking and suspend checks
	// --------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	// three samples cover the request, grant and start register stages
	sequence s_init; init_active_in [*3]; endsequence
	sequence s_mask; starts_masked_out [*3]; endsequence
	sequence s_call; subroutine_call_instr_in [*3]; endsequence
	sequence s_stop; !run_mode_in [*4]; endsequence
	a_start_shows_task: assert property (
		task_start_out |-> status_out.kind == tps_pkg::TPS_RUN_TASK
		&& status_out.task_id == task_start_id_out) else $error("start without status");
	a_init_blocks: assert property (s_init |-> !task_start_out)
		else $error("start during init");
	a_mask_blocks: assert property (s_mask |-> !task_start_out)
		else $error("start while masked");
	a_call_blocks: assert property (s_call |-> !task_start_out)
		else $error("start during call");
	a_mask_set: assert property (
		task_start_disable_instr_in && !task_start_enable_instr_in |=> starts_masked_out)
		else $error("mask not set");
	a_mask_clear: assert property (task_start_enable_instr_in |=> !starts_masked_out)
		else $error("mask not cleared");
	a_scan_suspended: assert property (
		status_out.kind != tps_pkg::TPS_RUN_SCAN |-> scan_suspend_out)
		else $error("scan not suspended");
	a_stop_no_request: assert property (
		s_stop |-> (pending_out & ~$past(pending_out)) == '0) else $error("request in stop");
endmodule
bind tps_scheduler tps_scheduler_monitor #(.NC(NC), .NI(NI)) tps_scheduler_monitor_inst (
	.core_clk_in, .sys_rst_in, .run_mode_in, .init_active_in, .task_start_disable_instr_in,
	.task_start_enable_instr_in, .subroutine_call_instr_in, .status_out, .scan_suspend_out,
	.task_start_out, .task_start_id_out, .pending_out, .starts_masked_out);

// >>> verif/tps_exec_model.sv
// execution core model: ends the shown task after a fixed run time
`timescale 1ns/1ps
module tps_exec_model #(
	parameter int RUN = 40
) (
	input  wire logic                 core_clk_in, // clock
	input  wire logic                 sys_rst_in,  // reset
	input  wire tps_pkg::tps_status_t status_in,   // shown task
	input  wire logic                 start_in,    // start pulse
	output logic                      done_out     // finish pulse
);
	// --------
	// run timer
	// --------
	int cnt;
	// restart on start or finish so a resumed task also runs its full time
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt      <= 0;
			done_out <= 1'b0;
		end else if (start_in || done_out || status_in.kind != tps_pkg::TPS_RUN_TASK) begin
			cnt      <= 0;
			done_out <= 1'b0;
		end else begin
			cnt      <= cnt + 1;
			done_out <= (cnt == RUN - 2);
		end
	end
endmodule

// >>> verif/tps_scheduler_tb.sv
// self-checking bench for the task priority scheduler
`timescale 1ns/1ps
module tps_scheduler_tb;
	// --------
	// stimulus, observation and bench tasks
	// --------
	logic                 core_clk_in;
	logic                 sys_rst_in = 1'b1;
	logic                 run        = 1'b1;
	logic                 init       = 1'b0;
	logic                 dis        = 1'b0;
	logic                 en         = 1'b0;
	logic                 call       = 1'b0;
	logic                 done;
	logic [7:0]           cyc_en     = 8'h00;
	logic [7:0]           pins       = 8'h08;
	logic [255:0]         cyc_iv     = 256'h1;
	logic [47:0]          prio       = {6'h3F, 6'h2D, 3'h3, 3'h7, 3'h2, 3'h3, {7{3'h7}}, 3'h6};
	tps_pkg::tps_status_t status;
	logic                 suspend, start, masked;
	logic [3:0]           start_id;
	logic [15:0]          pending;
	logic [3:0]           q[$];
	int                   err_total    = 0;
	int                   total_checks = 0;
	// 125 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	// pin 3 fires on falling edges, the others on rising edges
	tps_scheduler #(.MS_CYCLES(10)) tps_scheduler_inst (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .run_mode_in(run),
		.init_active_in(init), .task_start_disable_instr_in(dis),
		.task_start_enable_instr_in(en), .subroutine_call_instr_in(call), .task_done_in(done),
		.cyc_enable_in(cyc_en), .cyc_interval_in(cyc_iv), .io_enable_in(8'hFF),
		.io_edge_sel_in(8'h08), .external_interrupt_inputs_in(pins), .prio_cfg_in(prio),
		.status_out(status), .scan_suspend_out(suspend), .task_start_out(start),
		.task_start_id_out(start_id), .pending_out(pending), .starts_masked_out(masked));
	tps_exec_model tps_exec_model_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.status_in(status), .start_in(start), .done_out(done));
	// sampled at the falling edge, where the registered start pulse is settled
	always @(negedge core_clk_in)
		if (start === 1'b1)
			q.push_back(start_id);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask
	// toggle a pin and back; only one of the two edges is the selected one
	task automatic fire(input int i);
		pins[i] <= ~pins[i];
		cyc(3);
		pins[i] <= ~pins[i];
		cyc(3);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while ((suspend !== 1'b0 || pending !== 16'h0) && n < 3000) begin
			cyc(1);
			n++;
		end
		if (suspend !== 1'b0 || pending !== 16'h0) begin
			chk("idle", 16'h0, 16'h1);
			tally_and_finish();
		end
	endtask
	// ids packed as nibbles, first start leftmost
	task automatic seq(input int n, input logic [15:0] ids);
		chk("start_count", 16'(n), 16'(q.size()));
		for (int k = 0; k < n && k < q.size(); k++)
			chk("start_id", {12'h0, ids[4*(n-1-k)+:4]}, {12'h0, q[k]});
		q.delete();
	endtask
	initial begin
		cyc(6);
		sys_rst_in <= 1'b0;
		cyc(2);
		chk("status", 16'h0, {10'h0, status});
		dis <= 1'b1;
		cyc(1);
		dis <= 1'b0;
		fire(0);
		fire(0);
		fire(3);
		fire(1);
		chk("masked", 16'h1, {15'h0, masked});
		chk("pending", 16'h0B00, pending);
		seq(0, 16'h0);
		en <= 1'b1;
		cyc(1);
		en <= 1'b0;
		wait_idle();
		seq(3, 16'h098B);
		$display("test masked order done");
		fire(4);
		fire(5);
		fire(1);
		wait_idle();
		seq(3, 16'h0C9D);
		$display("test preempt done");
		dis <= 1'b1;
		init <= 1'b1;
		cyc(1);
		dis <= 1'b0;
		fire(0);
		chk("kind", 16'(tps_pkg::TPS_RUN_INIT), 16'(status.kind));
		seq(0, 16'h0);
		init <= 1'b0;
		en <= 1'b1;
		cyc(1);
		en <= 1'b0;
		call <= 1'b1;
		fire(1);
		seq(0, 16'h0);
		call <= 1'b0;
		wait_idle();
		seq(2, 16'h0098);
		$display("test init call done");
		run <= 1'b0;
		cyc_en <= 8'h01;
		fire(0);
		cyc(80);
		seq(0, 16'h0);
		run <= 1'b1;
		cyc(35);
		cyc_en <= 8'h00;
		wait_idle();
		seq(1, 16'h0);
		$display("test stop cyclic done");
		tally_and_finish();
	end
endmodule
